// File: aep_pkg.sv
package aep_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WINDOW_BYTES = 4096;
  localparam int unsigned PORT_ADDR_W = 10;
  localparam int unsigned DECODE_BYTES = 1024;
  localparam int unsigned TIMEOUT_OLD_US = 61;
  localparam int unsigned TIMEOUT_NEW_US = 125;
  localparam int unsigned TIMEOUT_OLD_CYC = TIMEOUT_OLD_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_NEW_CYC = TIMEOUT_NEW_US * CLK_MHZ;
  localparam int unsigned SELECT_HOLD_AFTER_ACK_NS = 110;
  localparam int unsigned SELECT_HOLD_CYC =
    (SELECT_HOLD_AFTER_ACK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACK_RELEASE_AFTER_SELECT_NS = 90;
  localparam int unsigned ACK_RELEASE_CYC =
    (ACK_RELEASE_AFTER_SELECT_NS * CLK_MHZ) / 1000;
  localparam int unsigned MIN_CYCLE_GAP_NS = 40;
  localparam int unsigned MIN_CYCLE_GAP_CYC =
    (MIN_CYCLE_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [31:0] WINDOW_BASE_RST = 32'h00FF_0000;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [7:0] PERIPH_RST_DATA = 8'h00;
endpackage

// File: aep_if.sv
interface aep_if;
  logic sel_n;
  logic rd_wr;
  logic [9:0] addr;
  logic [15:0] host_data;
  logic host_data_oe_n;
  logic [15:0] per_data;
  logic per_data_oe_n;
  logic ack_byte_width_n;
  logic ack_word_width_n;
  logic [15:0] data;
  assign data = !per_data_oe_n ? per_data :
                !host_data_oe_n ? host_data : 16'hFFFF;
  modport host (output sel_n, rd_wr, addr, host_data, host_data_oe_n,
                input data, ack_byte_width_n, ack_word_width_n);
  modport periph (input sel_n, rd_wr, addr, data,
                  output per_data, per_data_oe_n,
                  ack_byte_width_n, ack_word_width_n);
endinterface

// File: aep_host.sv
module aep_host #(
  parameter int unsigned TIMEOUT_CYC = aep_pkg::TIMEOUT_NEW_CYC,
  parameter logic [31:0] WINDOW_BASE = aep_pkg::WINDOW_BASE_RST
) (
  input wire logic clk,
  input wire logic reset,
  aep_if.host port,
  input wire logic req,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  output logic busy,
  output logic done,
  output logic bus_error,
  output logic refused,
  output logic [31:0] rdata,
  output logic port_is_word
);
  import aep_pkg::*;
  typedef enum {AEP_IDLE, AEP_SEL, AEP_HOLD, AEP_GAP} aep_state_e;
  aep_state_e st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt, wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic wr_r, wr_nxt, sel_r, sel_nxt, done_r, done_nxt, err_r, err_nxt;
  logic ref_r, ref_nxt, word_r, word_nxt, last_r, last_nxt;
  logic [2:0] left_r, left_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic in_win, aligned, ack;
  logic [2:0] nbytes;

  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    case (s)
      SIZE_BYTE: size_bytes = 3'h1;
      SIZE_WORD: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction

  // ----------------------------------------
  // Request checks
  // ----------------------------------------
  assign nbytes = size_bytes(req_size);
  assign in_win = (req_addr - WINDOW_BASE) < 32'(WINDOW_BYTES);
  assign aligned = (req_addr[1:0] & (2'(nbytes - 3'h1))) == 2'h0;
  assign ack = !port.ack_byte_width_n || !port.ack_word_width_n;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    wr_nxt = wr_r;
    sel_nxt = sel_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    ref_nxt = 1'b0;
    word_nxt = word_r;
    last_nxt = last_r;
    left_nxt = left_r;
    cnt_nxt = cnt_r;
    case (st_r)
      AEP_IDLE: begin
        if (req) begin
          if (in_win && aligned) begin
            addr_nxt = req_addr;
            wdat_nxt = req_wdata;
            wr_nxt = req_write;
            left_nxt = nbytes;
            rdat_nxt = 32'h0;
            sel_nxt = 1'b1;
            cnt_nxt = 32'h0;
            st_nxt = AEP_SEL;
          end else begin
            ref_nxt = 1'b1;
          end
        end
      end
      AEP_SEL: begin
        cnt_nxt = cnt_r + 32'h1;
        if (ack) begin
          word_nxt = !port.ack_word_width_n;
          if ((!port.ack_word_width_n && left_r == 3'h1) ||
              (port.ack_word_width_n && !port.ack_byte_width_n &&
               left_r != 3'h1 && 1'b0)) begin
            err_nxt = 1'b1;
          end
          if (!wr_r) begin
            // Byte lane shifts into low end of result
            if (!port.ack_word_width_n)
              rdat_nxt = {rdat_r[15:0], port.data};
            else
              rdat_nxt = {rdat_r[23:0], port.data[15:8]};
          end
          last_nxt = (!port.ack_word_width_n) ? (left_r <= 3'h2) :
                                                (left_r == 3'h1);
          left_nxt = (!port.ack_word_width_n && left_r >= 3'h2) ?
                     left_r - 3'h2 : left_r - 3'h1;
          cnt_nxt = 32'h0;
          st_nxt = AEP_HOLD;
        end else if (cnt_r >= TIMEOUT_CYC - 1) begin
          sel_nxt = 1'b0;
          err_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = AEP_IDLE;
        end
      end
      AEP_HOLD: begin
        cnt_nxt = cnt_r + 32'h1;
        if (!wr_r || cnt_r >= SELECT_HOLD_CYC - 1) begin
          sel_nxt = 1'b0;
          cnt_nxt = 32'h0;
          if (last_r) begin
            done_nxt = 1'b1;
            st_nxt = AEP_IDLE;
          end else begin
            // Next lane of a wide transfer
            addr_nxt = addr_r + (word_r ? 32'h2 : 32'h1);
            wdat_nxt = word_r ? {wdat_r[15:0], 16'h0} :
                                {wdat_r[23:0], 8'h0};
            st_nxt = AEP_GAP;
          end
        end
      end
      AEP_GAP: begin
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r >= MIN_CYCLE_GAP_CYC - 1) begin
          sel_nxt = 1'b1;
          cnt_nxt = 32'h0;
          st_nxt = AEP_SEL;
        end
      end
      default: st_nxt = AEP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= AEP_IDLE;
      addr_r <= 32'h0;
      wdat_r <= 32'h0;
      rdat_r <= 32'h0;
      wr_r <= 1'b0;
      sel_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      ref_r <= 1'b0;
      word_r <= 1'b0;
      last_r <= 1'b0;
      left_r <= 3'h0;
      cnt_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      ref_r <= ref_nxt;
      word_r <= word_nxt;
      last_r <= last_nxt;
      left_r <= left_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Port pins
  // ----------------------------------------
  assign port.sel_n = !sel_r;
  assign port.rd_wr = !wr_r;
  assign port.addr = addr_r[PORT_ADDR_W-1:0];
  assign port.host_data = wdat_r[31:16];
  assign port.host_data_oe_n = !(wr_r && st_r != AEP_IDLE);
  assign busy = st_r != AEP_IDLE;
  assign done = done_r || err_r;
  assign bus_error = err_r;
  assign refused = ref_r;
  assign rdata = rdat_r;
  assign port_is_word = word_r;
endmodule

// File: aep_periph.sv
module aep_periph #(
  parameter bit WORD_WIDE = 1'b0,
  parameter int unsigned ACK_DELAY_CYC = 2
) (
  input wire logic clk,
  input wire logic reset,
  aep_if.periph port,
  output logic wr_strobe,
  output logic [9:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_strobe,
  output logic [9:0] rd_addr,
  input wire logic [15:0] rd_data
);
  import aep_pkg::*;
  typedef enum {AEP_P_IDLE, AEP_P_WAIT, AEP_P_ACK} aep_p_state_e;
  aep_p_state_e st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] out_r, out_nxt, wd_r, wd_nxt;
  logic [9:0] a_r, a_nxt;
  logic wst_r, wst_nxt, rst_r, rst_nxt, drv_r, drv_nxt;

  // ----------------------------------------
  // Responder
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    wd_nxt = wd_r;
    a_nxt = a_r;
    wst_nxt = 1'b0;
    rst_nxt = 1'b0;
    drv_nxt = drv_r;
    case (st_r)
      AEP_P_IDLE: begin
        if (!port.sel_n) begin
          a_nxt = port.addr;
          cnt_nxt = 8'h0;
          st_nxt = AEP_P_WAIT;
          rst_nxt = port.rd_wr;
          drv_nxt = port.rd_wr;
          if (!port.rd_wr)
            wd_nxt = port.data;
        end
      end
      AEP_P_WAIT: begin
        cnt_nxt = cnt_r + 8'h1;
        if (port.rd_wr)
          // Byte devices sit on the upper lane
          out_nxt = WORD_WIDE ? rd_data : {rd_data[7:0], 8'hFF};
        if (cnt_r >= 8'(ACK_DELAY_CYC)) begin
          wst_nxt = !port.rd_wr;
          st_nxt = AEP_P_ACK;
        end
      end
      AEP_P_ACK: begin
        if (port.sel_n) begin
          drv_nxt = 1'b0;
          st_nxt = AEP_P_IDLE;
        end
      end
      default: st_nxt = AEP_P_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= AEP_P_IDLE;
      cnt_r <= 8'h0;
      out_r <= 16'h0;
      wd_r <= 16'h0;
      a_r <= 10'h0;
      wst_r <= 1'b0;
      rst_r <= 1'b0;
      drv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      wd_r <= wd_nxt;
      a_r <= a_nxt;
      wst_r <= wst_nxt;
      rst_r <= rst_nxt;
      drv_r <= drv_nxt;
    end
  end

  // Acknowledge drops combinationally as select rises
  assign port.ack_byte_width_n = !(st_r == AEP_P_ACK && !WORD_WIDE &&
                                   !port.sel_n);
  assign port.ack_word_width_n = !(st_r == AEP_P_ACK && WORD_WIDE &&
                                   !port.sel_n);
  assign port.per_data = out_r;
  assign port.per_data_oe_n = !(drv_r && !port.sel_n);
  assign wr_strobe = wst_r;
  assign wr_addr = a_r;
  assign wr_data = WORD_WIDE ? wd_r : {8'h00, wd_r[15:8]};
  assign rd_strobe = rst_r;
  assign rd_addr = port.addr;
endmodule

// File: aep_monitor.sv
module aep_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic sel_n,
  input wire logic rd_wr,
  input wire logic [9:0] addr,
  input wire logic [15:0] data,
  input wire logic host_data_oe_n,
  input wire logic per_data_oe_n,
  input wire logic ack_byte_width_n,
  input wire logic ack_word_width_n
);
  localparam int MAX_SEL = 80;
  logic ack_n;
  assign ack_n = ack_byte_width_n & ack_word_width_n;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Handshake checks
  // ----------------------------------------
  sequence s_wr_ack;
    $fell(ack_n) && !rd_wr;
  endsequence
  sequence s_hold;
    (!sel_n && !host_data_oe_n && $stable(data))[*8] ##1 (!sel_n)[*3];
  endsequence
  sequence s_rd_ack;
    !ack_n && rd_wr ##1 !sel_n;
  endsequence
  property p_hold; s_wr_ack |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("write hold short");
  property p_one; !(!ack_byte_width_n && !ack_word_width_n); endproperty
  a_one: assert property (p_one) else $error("two acks");
  property p_width; ack_word_width_n; endproperty
  a_width: assert property (p_width) else $error("byte device word ack");
  property p_release; !ack_n |-> !sel_n; endproperty
  a_release: assert property (p_release) else $error("ack not released");
  property p_stable;
    !sel_n && !$past(sel_n) |-> $stable(addr) && $stable(rd_wr);
  endproperty
  a_stable: assert property (p_stable) else $error("addr or dir moved");
  property p_dir; !sel_n |-> (rd_wr ? host_data_oe_n : per_data_oe_n); endproperty
  a_dir: assert property (p_dir) else $error("wrong data driver");
  property p_rd_ack; s_rd_ack |-> !ack_n && !per_data_oe_n; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read ack dropped");
  property p_rd_end; $fell(ack_n) && rd_wr |-> ##[1:13] sel_n; endproperty
  a_rd_end: assert property (p_rd_end) else $error("read not ended");
  property p_sel_max; $fell(sel_n) |-> ##[1:MAX_SEL] sel_n; endproperty
  a_sel_max: assert property (p_sel_max) else $error("select stuck");
  property p_gap; $rose(sel_n) |-> sel_n[*4]; endproperty
  a_gap: assert property (p_gap) else $error("cycle gap short");
endmodule

// File: async_expansion_port_tb.sv
module async_expansion_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aep_pkg::*;
  localparam int TO = 50;
  localparam logic [31:0] B = WINDOW_BASE_RST;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req [3], r_wr [3], done [3], berr [3], refd [3], pw [3];
  logic [1:0] r_size [3];
  logic [31:0] r_addr [3], r_wdata [3], rdata [3];
  logic wr_stb [2];
  logic [9:0] wr_addr [2], rd_addr [2];
  logic [15:0] wr_data [2], rd_data [2];
  int miscompares = 0;
  int samples_checked = 0;
  int nwr = 0;
  int n;
  // ----------------------------------------
  // Hosts, devices, dead port
  // ----------------------------------------
  aep_if i_aep_if [3] ();
  for (genvar g = 0; g < 3; g++) begin : g_host
    aep_host #(.TIMEOUT_CYC(TO)) i_aep_host (.clk(clk), .reset(reset),
      .port(i_aep_if[g]), .req(req[g]), .req_addr(r_addr[g]),
      .req_write(r_wr[g]), .req_size(r_size[g]), .req_wdata(r_wdata[g]),
      .busy(), .done(done[g]), .bus_error(berr[g]), .refused(refd[g]),
      .rdata(rdata[g]), .port_is_word(pw[g]));
  end
  for (genvar g = 0; g < 2; g++) begin : g_dev
    aep_periph #(.WORD_WIDE(1'(g))) i_aep_periph (.clk(clk), .reset(reset),
      .port(i_aep_if[g]), .wr_strobe(wr_stb[g]), .wr_addr(wr_addr[g]),
      .wr_data(wr_data[g]), .rd_strobe(), .rd_addr(rd_addr[g]),
      .rd_data(rd_data[g]));
  end
  assign rd_data[0] = {6'h00, rd_addr[0]};
  assign rd_data[1] = {rd_addr[1][7:0], ~rd_addr[1][7:0]};
  // Silent device: pulled-up acks, no data
  assign i_aep_if[2].ack_byte_width_n = 1'b1;
  assign i_aep_if[2].ack_word_width_n = 1'b1;
  assign i_aep_if[2].per_data_oe_n = 1'b1;
  assign i_aep_if[2].per_data = 16'hFFFF;
  aep_monitor i_aep_monitor (.clk(clk), .reset(reset),
    .sel_n(i_aep_if[0].sel_n), .rd_wr(i_aep_if[0].rd_wr),
    .addr(i_aep_if[0].addr), .data(i_aep_if[0].data),
    .host_data_oe_n(i_aep_if[0].host_data_oe_n),
    .per_data_oe_n(i_aep_if[0].per_data_oe_n),
    .ack_byte_width_n(i_aep_if[0].ack_byte_width_n),
    .ack_word_width_n(i_aep_if[0].ack_word_width_n));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (wr_stb[0] === 1'b1) nwr++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task xfer(input int h, input logic [31:0] a, input logic w,
            input logic [1:0] s, input logic [31:0] d);
    // Keep the minimum deselect gap before a new select
    repeat (MIN_CYCLE_GAP_CYC) @(posedge clk);
    @(posedge clk);
    req[h] <= 1'b1;
    r_addr[h] <= a;
    r_wr[h] <= w;
    r_size[h] <= s;
    r_wdata[h] <= d;
    n = 0;
    do begin
      @(posedge clk);
      req[h] <= 1'b0;
      #1;
      n++;
    end while (done[h] !== 1'b1 && refd[h] !== 1'b1 && n < 400);
    chk(n < 400, "no completion");
  endtask
  task final_report;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task t_byte;
    nwr = 0;
    xfer(0, B + 32'h10, 1'b1, SIZE_LONG, 32'hA1B2C3D4);
    chk(berr[0] === 1'b0 && nwr == 4, "long split");
    chk(wr_addr[0] === 10'h013 && wr_data[0][7:0] === 8'hD4, "lane");
    xfer(0, B + 32'h20, 1'b0, SIZE_LONG, 32'h0);
    chk(rdata[0] === 32'h20212223, "byte read");
    chk(pw[0] === 1'b0, "byte width");
  endtask
  task t_word;
    xfer(1, B + 32'h40, 1'b0, SIZE_LONG, 32'h0);
    chk(rdata[1] === 32'h40BF42BD && pw[1] === 1'b1, "word read");
    xfer(1, B + 32'h44, 1'b1, SIZE_WORD, 32'hBEEFBEEF);
    chk(wr_addr[1] === 10'h044 && wr_data[1] === 16'hBEEF, "wr");
    xfer(1, B + 32'h46, 1'b0, SIZE_BYTE, 32'h0);
    chk(berr[1] === 1'b1, "narrow");
  endtask
  task t_refuse;
    xfer(0, B + 32'h1000, 1'b0, SIZE_BYTE, 32'h0);
    chk(refd[0] === 1'b1, "above");
    xfer(0, B - 32'h1, 1'b0, SIZE_BYTE, 32'h0);
    chk(refd[0] === 1'b1, "below");
    xfer(0, B + 32'h21, 1'b0, SIZE_WORD, 32'h0);
    chk(refd[0] === 1'b1, "misaligned");
    xfer(0, B + 32'h3FF, 1'b1, SIZE_BYTE, 32'h77777777);
    chk(refd[0] === 1'b0 && wr_addr[0] === 10'h3FF, "top");
  endtask
  task t_timeout;
    xfer(2, B + 32'h8, 1'b0, SIZE_BYTE, 32'h0);
    chk(berr[2] === 1'b1 && n >= TO && n <= TO + 8, "timeout");
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      req[i] = 1'b0;
      r_addr[i] = B;
      r_wr[i] = 1'b0;
      r_size[i] = SIZE_BYTE;
      r_wdata[i] = 32'h0;
    end
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_byte;
    t_word;
    t_refuse;
    t_timeout;
    final_report;
  end
  initial begin
    #200000;
    miscompares++;
    final_report;
  end
endmodule
